// file: verilog/cdl_limiter.sv
// clip driven level limiter: shared stereo gain, clip detection,
// attack / hold / release control and an axi4-lite register slave
// assumes synchronous inputs on sys_clk and a single bus master
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cdl_limiter #(
  parameter int HOLD_UNIT_CYC = cdl_pkg::HOLD_UNIT_CYC
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output var  logic [1:0]        s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  // stereo stream in
  input  wire logic              in_valid,
  input  wire cdl_pkg::cdl_pair_t in_pair,
  // stereo stream out
  output var  logic              out_valid,
  output var  cdl_pkg::cdl_pair_t out_pair,
  // battery and gain
  input  wire logic              low_batt_in,
  output var  logic [15:0]       gain_out
);
  // registers and live state
  logic [31:0]               ctrl_reg;
  logic [31:0]               level_reg;
  logic [31:0]               cut_reg;
  cdl_pkg::cdl_state_t       state_reg;
  cdl_pkg::cdl_state_t       state_next;
  logic [15:0]               gain_reg;
  logic [15:0]               gain_next;
  logic [cdl_pkg::STEP_CNT_W-1:0] step_cnt_reg;
  logic [cdl_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
  logic [cdl_pkg::CUT_W-1:0] cut_cnt_reg;
  logic                      event_reg;
  logic                      clip_l;
  logic                      clip_r;
  logic                      sat_l;
  logic                      sat_r;
  logic                      out_valid_reg;
  cdl_pkg::cdl_pair_t        out_pair_reg;

  // write channel capture
  logic                      aw_held_reg;
  logic                      w_held_reg;
  logic [7:0]                awaddr_reg;
  logic [31:0]               wdata_reg;
  logic [3:0]                wstrb_reg;
  logic                      wr_go;

  // decoded fields
  logic                      enable;
  logic [cdl_pkg::SEL_W-1:0] attack_rate_sel;
  logic [cdl_pkg::SEL_W-1:0] release_rate_sel;
  logic [cdl_pkg::SEL_W-1:0] hold_duration_sel;
  logic [15:0]               target_gain;
  logic [15:0]               min_gain_floor;
  logic [cdl_pkg::CUT_W-1:0] per_event_cut_limit;
  logic [15:0]               tgt_eff;
  logic [cdl_pkg::STEP_CNT_W-1:0] step_period;
  logic [cdl_pkg::HOLD_CNT_W-1:0] hold_period;
  logic                      step_tick;
  logic                      hold_done;
  logic                      attack_step;

  assign enable            = ctrl_reg[cdl_pkg::CTRL_EN_BIT];
  assign attack_rate_sel   = ctrl_reg[cdl_pkg::CTRL_ATK_LSB +: 4];
  assign release_rate_sel  = ctrl_reg[cdl_pkg::CTRL_REL_LSB +: 4];
  assign hold_duration_sel = ctrl_reg[cdl_pkg::CTRL_HLD_LSB +: 4];
  assign target_gain       = level_reg[cdl_pkg::LVL_TGT_LSB +: 16];
  assign min_gain_floor    = level_reg[cdl_pkg::LVL_FLR_LSB +: 16];
  assign per_event_cut_limit = cut_reg[cdl_pkg::CUT_W-1:0];
  assign tgt_eff = cdl_pkg::floor_clamp(target_gain, min_gain_floor);

  // per-channel gain stages and clip detectors, same gain both sides
  cdl_gain_apply u_gain_l (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .in_valid   (in_valid),
    .in_sample  (in_pair.left),
    .gain       (gain_reg),
    .out_sample (out_pair_reg.left),
    .out_sat    (sat_l)
  );
  cdl_gain_apply u_gain_r (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .in_valid   (in_valid),
    .in_sample  (in_pair.right),
    .gain       (gain_reg),
    .out_sample (out_pair_reg.right),
    .out_sat    (sat_r)
  );
  cdl_clip_det u_clip_l (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .smp_valid (out_valid_reg),
    .sample    (out_pair_reg.left),
    .sat       (sat_l),
    .clip      (clip_l)
  );
  cdl_clip_det u_clip_r (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .smp_valid (out_valid_reg),
    .sample    (out_pair_reg.right),
    .sat       (sat_r),
    .clip      (clip_r)
  );

  // output valid follows the gain stage latency of one cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) out_valid_reg <= 1'b0;
    else out_valid_reg <= in_valid;
  end
  assign out_valid = out_valid_reg;
  assign out_pair  = out_pair_reg;
  assign gain_out  = gain_reg;

  // clip only counts while the battery is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) event_reg <= 1'b0;
    else event_reg <= (clip_l | clip_r) & low_batt_in;
  end

  // step period doubles per rate select code
  assign step_period = (state_reg == cdl_pkg::ST_RELEASE)
    ? (cdl_pkg::STEP_CNT_W'(cdl_pkg::STEP_UNIT_CYC) << release_rate_sel)
    : (cdl_pkg::STEP_CNT_W'(cdl_pkg::STEP_UNIT_CYC) << attack_rate_sel);
  assign step_tick   = (step_cnt_reg == step_period - 24'h000001);
  assign hold_period = cdl_pkg::HOLD_CNT_W'(HOLD_UNIT_CYC)
                       << hold_duration_sel;
  assign hold_done   = (hold_cnt_reg == hold_period - 32'h0000_0001);
  assign attack_step = step_tick && (cut_cnt_reg < per_event_cut_limit);

  // phase and gain decisions
  always_comb begin
    state_next = state_reg;
    gain_next  = gain_reg;
    unique case (state_reg)
      cdl_pkg::ST_IDLE: begin
        gain_next = tgt_eff;
        if (event_reg) state_next = cdl_pkg::ST_ATTACK;
      end
      cdl_pkg::ST_ATTACK: begin
        if (attack_step) begin
          gain_next = cdl_pkg::floor_clamp(
            cdl_pkg::step_down(gain_reg), min_gain_floor);
        end
        if (!event_reg) state_next = cdl_pkg::ST_HOLD;
      end
      cdl_pkg::ST_HOLD: begin
        gain_next = cdl_pkg::floor_clamp(gain_reg, min_gain_floor);
        if (event_reg) state_next = cdl_pkg::ST_ATTACK;
        else if (hold_done) state_next = cdl_pkg::ST_RELEASE;
      end
      cdl_pkg::ST_RELEASE: begin
        if (event_reg) begin
          state_next = cdl_pkg::ST_ATTACK;
        end else if (gain_reg >= tgt_eff) begin
          state_next = cdl_pkg::ST_IDLE;
          gain_next  = tgt_eff;
        end else if (step_tick) begin
          gain_next = cdl_pkg::floor_clamp(
            cdl_pkg::step_up(gain_reg, tgt_eff), min_gain_floor);
        end
      end
    endcase
    // disabled: gain simply follows the target
    if (!enable) begin
      state_next = cdl_pkg::ST_IDLE;
      gain_next  = tgt_eff;
    end
  end

  // phase and shared gain
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cdl_pkg::ST_IDLE;
      gain_reg  <= cdl_pkg::LEVEL_RST[cdl_pkg::LVL_TGT_LSB +: 16];
    end else begin
      state_reg <= state_next;
      gain_reg  <= gain_next;
    end
  end

  // step counter restarts on every phase change
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) step_cnt_reg <= '0;
    else if (state_next != state_reg || step_tick) step_cnt_reg <= '0;
    else if (state_reg == cdl_pkg::ST_ATTACK ||
             state_reg == cdl_pkg::ST_RELEASE)
      step_cnt_reg <= step_cnt_reg + 24'h000001;
  end

  // hold timer counts from the last clip, cleared outside hold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hold_cnt_reg <= '0;
    else if (state_reg != cdl_pkg::ST_HOLD || event_reg)
      hold_cnt_reg <= '0;
    else if (!hold_done) hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
  end

  // per-event cut budget, fresh on each entry into attack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cut_cnt_reg <= '0;
    else if (state_reg != cdl_pkg::ST_ATTACK) cut_cnt_reg <= '0;
    else if (attack_step) cut_cnt_reg <= cut_cnt_reg + 8'h01;
  end

  // write channels are taken independently, answered once both held
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      awaddr_reg    <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      w_held_reg   <= 1'b0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // register writes and write response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg     <= cdl_pkg::CTRL_RST;
      level_reg    <= cdl_pkg::LEVEL_RST;
      cut_reg      <= cdl_pkg::CUT_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cdl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= cdl_pkg::RESP_OKAY;
      unique case (awaddr_reg)
        cdl_pkg::ADDR_CTRL:
          ctrl_reg <= cdl_pkg::strb_merge(ctrl_reg, wdata_reg, wstrb_reg);
        cdl_pkg::ADDR_LEVEL:
          level_reg <= cdl_pkg::strb_merge(level_reg, wdata_reg,
                                           wstrb_reg);
        cdl_pkg::ADDR_CUT:
          cut_reg <= cdl_pkg::strb_merge(cut_reg, wdata_reg, wstrb_reg);
        cdl_pkg::ADDR_STATUS: ; // read only, write ignored
        default: s_axi_bresp <= cdl_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reads: one outstanding, data captured at the address handshake
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cdl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= cdl_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cdl_pkg::ADDR_CTRL:   s_axi_rdata <= ctrl_reg;
        cdl_pkg::ADDR_LEVEL:  s_axi_rdata <= level_reg;
        cdl_pkg::ADDR_CUT:    s_axi_rdata <= cut_reg;
        cdl_pkg::ADDR_STATUS: begin
          s_axi_rdata <= {8'h00, low_batt_in, clip_r, clip_l, event_reg,
                          state_reg, gain_reg};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= cdl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verilog/cdl_pkg.sv
// constants, types and helpers shared by the clip driven level limiter
// assumes a 125 MHz system clock and 16-bit signed audio samples
package cdl_pkg;

  // clock and time base
  localparam int CLK_NS        = 8;
  localparam int STEP_UNIT_NS  = 1000;
  localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_UNIT_NS  = 1000000;
  localparam int HOLD_UNIT_CYC = (HOLD_UNIT_NS + CLK_NS - 1) / CLK_NS;

  // widths
  localparam int SAMPLE_W   = 16;
  localparam int GAIN_W     = 16;
  localparam int GAIN_FRAC  = 14;
  localparam int STEP_SHIFT = 6;
  localparam int SEL_W      = 4;
  localparam int CUT_W      = 8;
  localparam int STEP_CNT_W = 24;
  localparam int HOLD_CNT_W = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEVEL  = 8'h04;
  localparam logic [7:0] ADDR_CUT    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ATK_LSB = 4;
  localparam int CTRL_REL_LSB = 8;
  localparam int CTRL_HLD_LSB = 12;
  localparam int LVL_TGT_LSB  = 0;
  localparam int LVL_FLR_LSB  = 16;
  localparam int ST_STATE_LSB = 16;
  localparam int ST_EVENT_BIT = 20;
  localparam int ST_CLIPL_BIT = 21;
  localparam int ST_CLIPR_BIT = 22;
  localparam int ST_BATT_BIT  = 23;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_3420;
  localparam logic [31:0] LEVEL_RST = 32'h1000_4000;
  localparam logic [31:0] CUT_RST   = 32'h0000_0018;

  // clip level and bus answers
  localparam logic [SAMPLE_W:0] CLIP_MAG    = 17'h07fff;
  localparam logic [1:0]        RESP_OKAY   = 2'b00;
  localparam logic [1:0]        RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ATTACK  = 4'b0010,
    ST_HOLD    = 4'b0100,
    ST_RELEASE = 4'b1000
  } cdl_state_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } cdl_pair_t;

  // one attack step, g * (1 - 1/64)
  function automatic logic [GAIN_W-1:0] step_down(
    input logic [GAIN_W-1:0] g);
    step_down = g - (g >> STEP_SHIFT);
  endfunction

  // one release step, saturating, never past the target
  function automatic logic [GAIN_W-1:0] step_up(
    input logic [GAIN_W-1:0] g, input logic [GAIN_W-1:0] tgt);
    logic [GAIN_W:0] s;
    s = {1'b0, g} + {1'b0, (g >> STEP_SHIFT)} + 17'h00001;
    if (s >= {1'b0, tgt}) step_up = tgt;
    else step_up = s[GAIN_W-1:0];
  endfunction

  // keep a gain at or above the floor
  function automatic logic [GAIN_W-1:0] floor_clamp(
    input logic [GAIN_W-1:0] g, input logic [GAIN_W-1:0] flr);
    floor_clamp = (g < flr) ? flr : g;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] strb_merge(
    input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      strb_merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

endpackage

// file: verilog/cdl_gain_apply.sv
// one channel gain stage: sample times shared gain, saturated
// assumes gain in unsigned 2.14 format, unity at 0x4000
`timescale 1ns/100ps
`default_nettype none
module cdl_gain_apply (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  // sample in
  input  wire logic                                in_valid,
  input  wire logic signed [cdl_pkg::SAMPLE_W-1:0] in_sample,
  input  wire logic        [cdl_pkg::GAIN_W-1:0]   gain,
  // sample out
  output var  logic signed [cdl_pkg::SAMPLE_W-1:0] out_sample,
  output var  logic                                out_sat
);
  logic signed [32:0] prod;
  logic        [18:0] scaled;
  logic               ovf;

  // drop fraction bits; overflow when top bits disagree
  assign prod   = in_sample * $signed({1'b0, gain});
  assign scaled = prod[32:cdl_pkg::GAIN_FRAC];
  assign ovf    = (scaled[18:15] != {4{scaled[15]}});

  // registered, saturating instead of wrapping avoids loud pops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_sample <= 16'sh0000;
      out_sat    <= 1'b0;
    end else if (in_valid) begin
      out_sat <= ovf;
      if (!ovf) out_sample <= $signed(scaled[15:0]);
      else if (scaled[18]) out_sample <= 16'sh8000;
      else out_sample <= 16'sh7fff;
    end
  end
endmodule
`default_nettype wire

// file: verilog/cdl_clip_det.sv
// clip detector for one output channel
// assumes the gain stage reports saturation alongside each sample
`timescale 1ns/100ps
`default_nettype none
module cdl_clip_det (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  // watched sample
  input  wire logic                                smp_valid,
  input  wire logic signed [cdl_pkg::SAMPLE_W-1:0] sample,
  input  wire logic                                sat,
  // flag
  output var  logic                                clip
);
  logic [cdl_pkg::SAMPLE_W:0] mag;

  // magnitude widened so that -32768 does not wrap
  assign mag = sample[cdl_pkg::SAMPLE_W-1]
             ? 17'(-$signed({sample[15], sample}))
             : {1'b0, sample};

  // flag holds per sample until the next one arrives
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) clip <= 1'b0;
    else if (smp_valid) clip <= sat || (mag >= cdl_pkg::CLIP_MAG);
  end
endmodule
`default_nettype wire

// file: verif/cdl_chk_assertions.sv
// checker for cdl_limiter: gain steps, hold, bus and stream timing
// sees only the top ports; bound to every cdl_limiter below
`timescale 1ns/100ps
`default_nettype none
module cdl_chk #(
  parameter int HOLD_UNIT_CYC = cdl_pkg::HOLD_UNIT_CYC
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rstn,
  // bus handshakes
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [7:0]         s_axi_araddr,
  input wire logic               s_axi_rvalid,
  input wire logic [1:0]         s_axi_rresp,
  // stream and gain
  input wire logic               in_valid,
  input wire cdl_pkg::cdl_pair_t in_pair,
  input wire logic               out_valid,
  input wire cdl_pkg::cdl_pair_t out_pair,
  input wire logic               low_batt_in,
  input wire logic [15:0]        gain_out
);
  logic [2:0]  quiet;
  logic [15:0] lo_cnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // register writes move the gain freely, so gain checks wait them out
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) quiet <= 3'h0;
    else if (s_axi_awvalid && s_axi_awready) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end

  // cycles since the battery indicator was last high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lo_cnt <= 16'h0;
    else if (low_batt_in) lo_cnt <= 16'h0;
    else if (lo_cnt != 16'hffff) lo_cnt <= lo_cnt + 16'h1;
  end

  property p_dn_step;
    quiet == 3'h7 && gain_out < $past(gain_out) |->
      gain_out >= $past(gain_out) - ($past(gain_out) >> 6);
  endproperty
  a_dn_step: assert property (p_dn_step)
    else $error("gain cut deeper than one step");

  property p_no_cut;
    quiet == 3'h7 && lo_cnt >= 16'd6 |-> gain_out >= $past(gain_out);
  endproperty
  a_no_cut: assert property (p_no_cut)
    else $error("gain cut without low battery");

  property p_up_step;
    quiet == 3'h7 && gain_out > $past(gain_out) |->
      gain_out <= $past(gain_out) + ($past(gain_out) >> 6) + 16'h1;
  endproperty
  a_up_step: assert property (p_up_step)
    else $error("gain raised faster than one step");

  property p_hold;
    quiet == 3'h7 && gain_out > $past(gain_out) |->
      lo_cnt >= HOLD_UNIT_CYC;
  endproperty
  a_hold: assert property (p_hold)
    else $error("gain raised inside hold time");

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");

  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid; // held halves meet, then the answer
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");

  property p_slverr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
      |=> s_axi_rresp == 2'b10;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped read not refused");

  property p_stereo;
    in_valid && in_pair.left == in_pair.right |=>
      out_valid && out_pair.left == out_pair.right;
  endproperty
  a_stereo: assert property (p_stereo)
    else $error("channels got different gain");
endmodule

bind cdl_limiter cdl_chk #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC)) chk_u (
  .sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rresp, .in_valid, .in_pair,
  .out_valid, .out_pair, .low_batt_in, .gain_out
);
`default_nettype wire

// file: verif/cdl_src.sv
// stereo sample source standing in for the playback path
// one pair every PERIOD cycles, no back-pressure possible
`timescale 1ns/100ps
`default_nettype none
module cdl_src #(
  parameter int PERIOD = 4
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // amplitude chosen by the bench
  input  wire cdl_pkg::cdl_pair_t amp,
  // stream to the limiter
  output var  logic               in_valid,
  output var  cdl_pkg::cdl_pair_t in_pair
);
  int cnt;

  // data is not held between strobes, so it toggles there
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt      <= 0;
      in_valid <= 1'b0;
      in_pair  <= '0;
    end else if (cnt == PERIOD - 1) begin
      cnt      <= 0;
      in_valid <= 1'b1;
      in_pair  <= amp;
    end else begin
      cnt      <= cnt + 1;
      in_valid <= 1'b0;
      in_pair  <= ~in_pair;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// testbench for cdl_limiter: registers, stream and limiter phases
// short hold unit; a sample source model feeds the stream
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int HU = 16;
  logic               sys_clk, rstn, awv, awr, wv, wrdy, bv, br;
  logic               arv, arr, rv, rr, in_valid, out_valid, low_batt;
  logic [7:0]         awa, ara;
  logic [31:0]        wd, rdd;
  logic [1:0]         bresp, rresp;
  logic [15:0]        gain;
  cdl_pkg::cdl_pair_t amp, in_pair, out_pair;
  int                 err_count, n_checks;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  cdl_limiter #(.HOLD_UNIT_CYC(HU)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdd), .s_axi_rresp(rresp), .in_valid(in_valid),
    .in_pair(in_pair), .out_valid(out_valid), .out_pair(out_pair),
    .low_batt_in(low_batt), .gain_out(gain)
  );

  cdl_src #(.PERIOD(4)) src_u (
    .sys_clk(sys_clk), .rstn(rstn), .amp(amp),
    .in_valid(in_valid), .in_pair(in_pair)
  );

  task automatic close_out();
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int   n;
    logic dn;
    n = 0;
    dn = 1'b0;
    @(posedge sys_clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    while (!dn) begin
      @(posedge sys_clk);
      n++;
      if (n > 100) hang();
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        chk({30'h0, bresp}, {30'h0, er});
        br <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] d);
    int   n;
    logic dn;
    n = 0;
    dn = 1'b0;
    d = 32'h0;
    @(posedge sys_clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    while (!dn) begin
      @(posedge sys_clk);
      n++;
      if (n > 100) hang();
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        chk({30'h0, rresp}, {30'h0, er});
        d = rdd;
        rr <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask

  task automatic wgain(input logic [15:0] e, input int lim);
    int n;
    n = 0;
    while (gain !== e) begin
      @(posedge sys_clk);
      n++;
      if (n > lim) hang();
    end
    chk({16'h0, gain}, {16'h0, e});
  endtask

  // state and gain fields of the status word
  task automatic st(input logic [3:0] s, input logic [15:0] g);
    logic [31:0] d;
    axr(8'h0c, 2'b00, d);
    chk(d & 32'h000f_ffff, {12'h0, s, g});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    axr(8'h00, 2'b00, d);
    chk(d, 32'h0000_3420);
    axr(8'h04, 2'b00, d);
    chk(d, 32'h1000_4000);
    axr(8'h08, 2'b00, d);
    chk(d, 32'h0000_0018);
    st(4'h1, 16'h4000);
    axr(8'h10, 2'b10, d);
    chk(d, 32'h0);
    axw(8'h14, 32'hffff_ffff, 2'b10);
    axw(8'h0c, 32'h0, 2'b00);
    st(4'h1, 16'h4000);
  endtask

  task automatic t_stereo();
    int m;
    m = 0;
    amp <= {16'h1000, 16'hf800};
    axw(8'h04, 32'h1000_8000, 2'b00);
    wgain(16'h8000, 20);
    repeat (12) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      m++;
      if (m > 20) hang();
    end while (!out_valid);
    chk(out_pair, 32'h2000_f000);
  endtask

  // left channel alone clips; cut budget of two steps
  task automatic t_attack();
    amp <= {16'h7fff, 16'h0000};
    axw(8'h08, 32'h2, 2'b00);
    axw(8'h00, 32'h0000_1111, 2'b00); // rate and hold codes of one
    repeat (400) @(posedge sys_clk);
    chk({16'h0, gain}, 32'h8000);
    low_batt <= 1'b1;
    wgain(16'h7e00, 400);
    wgain(16'h7c08, 400);
    repeat (400) @(posedge sys_clk);
    st(4'h2, 16'h7c08);
  endtask

  task automatic t_release();
    low_batt <= 1'b0;
    repeat (6) @(posedge sys_clk);
    st(4'h4, 16'h7c08);
    low_batt <= 1'b1;
    wgain(16'h7a18, 400);
    wgain(16'h7830, 400);
    low_batt <= 1'b0;
    wgain(16'h8000, 3000);
    st(4'h1, 16'h8000);
  endtask

  // right channel alone clips; floor stops the cut
  task automatic t_floor();
    amp <= {16'h0000, 16'h7fff};
    axw(8'h08, 32'hff, 2'b00);
    axw(8'h04, 32'h7000_8000, 2'b00);
    low_batt <= 1'b1;
    wgain(16'h7000, 3000);
    repeat (500) @(posedge sys_clk);
    chk({16'h0, gain}, 32'h7000);
    low_batt <= 1'b0;
    wgain(16'h8000, 4000);
  endtask

  initial begin
    rstn = 1'b0;
    {awv, wv, br, arv, rr, low_batt} = 6'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    amp = '0;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_stereo();
    t_attack();
    t_release();
    t_floor();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    hang();
  end
endmodule
`default_nettype wire
